// ### inc/acsc_defs.svh
/*
 Named constants of the converter start control: register space, control
 register address, reset value, bit positions and sequencing counts.
 Assumes a 50 MHz system clock and a SAR clock derived from it.
*/
// Contract
// R1: Track mode bit set: a window starts only on the chosen start source.
// R2: Low power, source 001: timer 0 overflow, 3 SAR clocks track, convert.
// R3: Low power, source 010: timer 2 overflow, 3 SAR clocks track, convert.
// R4: Low power, source 101: timer 3 overflow, 3 SAR clocks track, convert.
// R5: Window flag sets on a matching result and holds until software clears.
// R6: Register space answers 0x80 to 0xFF; control register sits at 0xE8.
// R7: Addresses ending 0x0 or 0x8 take bit and byte access, others byte only.
// R8: Software leaves unoccupied addresses alone; their effect is undefined.
// R9: Busy=1 at source 000 starts; busy reads 1 until the end, then done sets.
// R10: Enable low: shut down; normal mode tracks except while converting.
`ifndef ACSC_DEFS_SVH
`define ACSC_DEFS_SVH

`define ACSC_SPACE_LO      8'h80
`define ACSC_SPACE_HI      8'hFF
`define ACSC_CTRL_ADDR     8'hE8
`define ACSC_CTRL_RST      8'h00
`define ACSC_BIT_ADDR_LOW  3'h0
`define ACSC_BUSY_BIT      3'h4
`define ACSC_TM_BIT        3'h6
`define ACSC_SRC_SW        3'h0
`define ACSC_SRC_T0        3'h1
`define ACSC_SRC_T2        3'h2
`define ACSC_SRC_T1        3'h3
`define ACSC_SRC_EXT       3'h4
`define ACSC_SRC_T3        3'h5
`define ACSC_SYSCLK_HZ     50000000
`define ACSC_SARCLK_MAX_HZ 3000000
`define ACSC_SAR_DIV       ((`ACSC_SYSCLK_HZ + `ACSC_SARCLK_MAX_HZ - 1) \
                            / `ACSC_SARCLK_MAX_HZ)
`define ACSC_TRACK_TICKS   3
`define ACSC_CONV_TICKS    10

`endif

// ### inc/acsc_pkg.sv
/*
 Types of the converter start control: register layout, bus request,
 trigger bundle and sequencer states.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package acsc_pkg;

   typedef struct packed {
      logic       en;
      logic       tm;
      logic       done;
      logic       busy;
      logic       wint;
      logic [2:0] cm;
   } acsc_ctrl_t;

   // Bit operations carry their data in wdata[0]
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic       bitOp;
      logic [2:0] bitIdx;
      logic [7:0] wdata;
   } acsc_sfr_req_t;

   typedef struct packed {
      logic t0;
      logic t1;
      logic t2;
      logic t3;
   } acsc_trig_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_TRACK = 3'b010,
      ST_CONV  = 3'b100
   } acsc_state_t;

endpackage : acsc_pkg
`default_nettype wire

// ### hdl/acsc_sar_clk.sv
/*
 SAR clock tick generator: one-cycle tick every divider period.
 Assumes restart is pulsed on each sequencer state change.
*/
`include "acsc_defs.svh"
`default_nettype none
module acsc_sar_clk (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Phase control
   input  wire logic restart,
   output logic      tick
);
   localparam logic [4:0] DivLast = 5'(`ACSC_SAR_DIV - 1);

   logic [4:0] divCnt_r;

   // Restart aligns windows to whole SAR clocks from state entry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCnt_r <= 5'h00;
      end else if (restart || divCnt_r == DivLast) begin
         divCnt_r <= 5'h00;
      end else begin
         divCnt_r <= divCnt_r + 5'h01;
      end
   end

   // Tick comes from the counter alone; gating it by restart would loop
   // back through the sequencer's next-state logic
   assign tick = divCnt_r == DivLast;

endmodule : acsc_sar_clk
`default_nettype wire

// ### hdl/acsc_top.sv
/*
 Converter start-of-conversion control with its control/status register
 in the special register space.
 Assumes a CPU bus on the same clock and an async external start pin.
*/
`include "acsc_defs.svh"
`default_nettype none
module acsc_top (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Special register space
   input  wire acsc_pkg::acsc_sfr_req_t sfrReq,
   output logic [7:0]                   sfrRdata,
   output logic                         sfrRdValid,
   output logic                         sfrHit,
   // Triggers
   input  wire acsc_pkg::acsc_trig_t    timerOvf,
   input  wire logic                    externalConvertStartPin,
   // Converter core
   input  wire logic                    windowMatch,
   output logic                         converterEnable,
   output logic                         trackActive,
   output logic                         convActive,
   output logic                         sarTick,
   output logic                         convDone
);
   import acsc_pkg::*;

   localparam logic [3:0] TrackLast = 4'(`ACSC_TRACK_TICKS - 1);
   localparam logic [3:0] ConvLast  = 4'(`ACSC_CONV_TICKS - 1);
   localparam acsc_ctrl_t CtrlRst = acsc_ctrl_t'(`ACSC_CTRL_RST);
   localparam int TrackCyc = `ACSC_TRACK_TICKS * `ACSC_SAR_DIV;
   localparam int ConvCyc  = `ACSC_CONV_TICKS * `ACSC_SAR_DIV;

   acsc_state_t state_r;
   acsc_state_t state_nxt;
   acsc_ctrl_t  readVal;
   acsc_ctrl_t  wrVal;
   logic        enable_r;
   logic        trackMode_r;
   logic        doneFlag_r;
   logic        winFlag_r;
   logic [2:0]  srcSel_r;
   logic [3:0]  tickCnt_r;
   logic [7:0]  rdData_r;
   logic        rdValid_r;
   logic        convDone_r;
   logic        cnvMeta_r;
   logic        cnvSync_r;
   logic        cnvPrev_r;
   logic        cnvEdge;
   logic        wrHit;
   logic        srcHit;
   logic        swStart;
   logic        startReq;
   logic        convEnd;
   logic        restart;
   logic [7:0]  cycCnt_r;
   logic [7:0]  bitMerge;

   function automatic logic inSpace(input logic [7:0] a);
      return a >= `ACSC_SPACE_LO && a <= `ACSC_SPACE_HI;
   endfunction : inSpace

   function automatic logic isBitAddr(input logic [7:0] a);
      return a[2:0] == `ACSC_BIT_ADDR_LOW;
   endfunction : isBitAddr

   // R6 address decode
   // R7 bit access only where address allows
   assign sfrHit = inSpace(sfrReq.addr) && sfrReq.addr == `ACSC_CTRL_ADDR
                   && (!sfrReq.bitOp || isBitAddr(sfrReq.addr));
   assign wrHit  = sfrHit && sfrReq.wr;

   // R9 busy reads from sequencer
   always_comb begin
      readVal = acsc_ctrl_t'({enable_r, trackMode_r, doneFlag_r,
                              state_r != ST_IDLE, winFlag_r, srcSel_r});
      bitMerge = readVal;
      bitMerge[sfrReq.bitIdx] = sfrReq.wdata[0];
      wrVal = sfrReq.bitOp ? acsc_ctrl_t'(bitMerge)
                           : acsc_ctrl_t'(sfrReq.wdata);
   end

   // Plain control fields
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_r    <= CtrlRst.en;
         trackMode_r <= CtrlRst.tm;
         srcSel_r    <= CtrlRst.cm;
      end else if (wrHit) begin
         enable_r    <= wrVal.en;
         trackMode_r <= wrVal.tm;
         srcSel_r    <= wrVal.cm;
      end
   end

   // R5 window flag, hardware set beats software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         doneFlag_r <= CtrlRst.done;
         winFlag_r  <= CtrlRst.wint;
      end else begin
         // R9 done flag at conversion end
         doneFlag_r <= convEnd ? 1'b1 : (wrHit ? wrVal.done : doneFlag_r);
         winFlag_r  <= (convEnd && windowMatch) ? 1'b1
                       : (wrHit ? wrVal.wint : winFlag_r);
      end
   end

   // Registered read data, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData_r  <= 8'h00;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= sfrHit && sfrReq.rd;
         if (sfrHit && sfrReq.rd) begin
            rdData_r <= sfrReq.bitOp ? {7'h00, readVal[sfrReq.bitIdx]}
                                     : readVal;
         end
      end
   end

   // External start pin: two stages before any logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {cnvMeta_r, cnvSync_r, cnvPrev_r} <= 3'b000;
      end else begin
         cnvMeta_r <= externalConvertStartPin;
         cnvSync_r <= cnvMeta_r;
         cnvPrev_r <= cnvSync_r;
      end
   end
   assign cnvEdge = cnvSync_r && !cnvPrev_r;

   // R9 software start only with source 000
   assign swStart = wrHit && wrVal.busy && srcSel_r == `ACSC_SRC_SW;

   // R1 trigger chosen by start source
   always_comb begin
      unique case (srcSel_r)
         `ACSC_SRC_SW:  srcHit = swStart;
         // R2 timer 0 trigger
         `ACSC_SRC_T0:  srcHit = timerOvf.t0;
         // R3 timer 2 trigger
         `ACSC_SRC_T2:  srcHit = timerOvf.t2;
         `ACSC_SRC_T1:  srcHit = timerOvf.t1;
         `ACSC_SRC_EXT: srcHit = cnvEdge;
         // R4 timer 3 trigger
         `ACSC_SRC_T3:  srcHit = timerOvf.t3;
         default:       srcHit = 1'b0;
      endcase
   end
   assign startReq = enable_r && srcHit;

   // Triggers arriving while busy are dropped, not queued
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            // R1 low power mode tracks first
            if (startReq) begin
               state_nxt = trackMode_r ? ST_TRACK : ST_CONV;
            end
         end
         ST_TRACK: begin
            // R2 three SAR clock window then convert
            if (sarTick && tickCnt_r == TrackLast) begin
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (sarTick && tickCnt_r == ConvLast) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // R10 shutdown forces idle
      if (!enable_r) begin
         state_nxt = ST_IDLE;
      end
   end

   assign restart = state_nxt != state_r;
   assign convEnd = enable_r && state_r == ST_CONV && state_nxt == ST_IDLE;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tickCnt_r <= 4'h0;
      end else if (restart) begin
         tickCnt_r <= 4'h0;
      end else if (sarTick) begin
         tickCnt_r <= tickCnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         convDone_r <= 1'b0;
      end else begin
         convDone_r <= convEnd;
      end
   end

   acsc_sar_clk u_sarClk (
      .clk     (clk),
      .rst     (rst),
      .restart (restart),
      .tick    (sarTick)
   );

   assign sfrRdata        = rdData_r;
   assign sfrRdValid      = rdValid_r;
   assign converterEnable = enable_r;
   assign convActive      = state_r == ST_CONV;
   // R10 continuous tracking in normal mode
   assign trackActive     = enable_r && (trackMode_r ? state_r == ST_TRACK
                                                     : state_r != ST_CONV);
   assign convDone        = convDone_r;

   // Cycles spent in the current state, read only by checks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cycCnt_r <= 8'h00;
      end else if (restart) begin
         cycCnt_r <= 8'h00;
      end else begin
         cycCnt_r <= cycCnt_r + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_lp_gate;
      state_r == ST_IDLE && enable_r && trackMode_r
      && srcSel_r == `ACSC_SRC_T0 && !timerOvf.t0 |=> state_r == ST_IDLE;
   endproperty
   a_lp_gate: assert property (p_lp_gate) // R1
      else $error("low power window began without its trigger");

   property p_t0_start;
      state_r == ST_IDLE && enable_r && trackMode_r
      && srcSel_r == `ACSC_SRC_T0 && timerOvf.t0 |=> state_r == ST_TRACK;
   endproperty
   a_t0_start: assert property (p_t0_start) // R2
      else $error("timer 0 overflow did not open tracking");

   property p_track_len;
      state_r == ST_TRACK && state_nxt == ST_CONV
      |-> int'(cycCnt_r) == TrackCyc - 1;
   endproperty
   a_track_len: assert property (p_track_len) // R2
      else $error("tracking window not three SAR clocks");

   property p_t2_start;
      state_r == ST_IDLE && enable_r && trackMode_r
      && srcSel_r == `ACSC_SRC_T2 && timerOvf.t2 |=> state_r == ST_TRACK;
   endproperty
   a_t2_start: assert property (p_t2_start) // R3
      else $error("timer 2 overflow did not open tracking");

   property p_t3_start;
      state_r == ST_IDLE && enable_r && trackMode_r
      && srcSel_r == `ACSC_SRC_T3 && timerOvf.t3
      |=> state_r == ST_TRACK ##1 state_r == ST_TRACK;
   endproperty
   a_t3_start: assert property (p_t3_start) // R4
      else $error("timer 3 overflow did not open tracking");

   property p_win_set;
      convEnd && windowMatch |=> winFlag_r && convDone ##1 winFlag_r;
   endproperty
   a_win_set: assert property (p_win_set) // R5
      else $error("window flag missed a matching result");

   property p_win_hold;
      winFlag_r && !wrHit |=> winFlag_r;
   endproperty
   a_win_hold: assert property (p_win_hold) // R5
      else $error("window flag dropped without a write");

   property p_read;
      sfrReq.rd && !sfrReq.bitOp && sfrReq.addr == `ACSC_CTRL_ADDR
      |=> sfrRdValid && sfrRdata == $past(readVal);
   endproperty
   a_read: assert property (p_read) // R6
      else $error("control register read returned wrong data");

   property p_bit_write;
      sfrReq.wr && sfrReq.bitOp && sfrReq.addr == `ACSC_CTRL_ADDR
      && sfrReq.bitIdx == `ACSC_TM_BIT
      |=> trackMode_r == $past(sfrReq.wdata[0]);
   endproperty
   a_bit_write: assert property (p_bit_write) // R7
      else $error("bit write did not reach track mode");

   property p_sw_conv;
      state_r == ST_IDLE && enable_r && !trackMode_r && swStart
      |=> readVal.busy [*8] ##[1:200] convDone;
   endproperty
   a_sw_conv: assert property (p_sw_conv) // R9
      else $error("software start did not run a conversion");

   property p_conv_len;
      convEnd |-> int'(cycCnt_r) == ConvCyc - 1 ##1 !readVal.busy
                  && doneFlag_r;
   endproperty
   a_conv_len: assert property (p_conv_len) // R9
      else $error("conversion length or end flags wrong");

   property p_shutdown;
      !enable_r |-> !trackActive ##1 state_r == ST_IDLE;
   endproperty
   a_shutdown: assert property (p_shutdown) // R10
      else $error("converter active while disabled");

endmodule : acsc_top
`default_nettype wire

// ### bench/acsc_cpu_model.sv
/*
 CPU side of the special register space: one task per access cycle.
 Assumes the bench calls acc just after a rising edge of clk.
*/
`default_nettype none
module acsc_cpu_model (
   // Clock
   input  wire logic                   clk,
   // Register bus
   output var  acsc_pkg::acsc_sfr_req_t sfrReq,
   input  wire logic [7:0]             sfrRdata,
   input  wire logic                   sfrRdValid
);
   import acsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   initial sfrReq = '0;

   task automatic acc(input logic [7:0] a, input logic w, input logic b,
                      input logic [2:0] i, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
      // Idle edge first so a strobe is never driven twice in one step
      @(posedge clk);
      #1;
      sfrReq = '{addr:a, wr:w, rd:!w, bitOp:b, bitIdx:i, wdata:d};
      @(posedge clk);
      #1;
      q = sfrRdata;
      v = sfrRdValid;
      // Released lines show garbage, not the last value
      sfrReq = '{addr:~a, wr:1'b0, rd:1'b0, bitOp:~b, bitIdx:~i, wdata:~d};
   endtask : acc
endmodule : acsc_cpu_model
`default_nettype wire

// ### bench/tb.sv
/*
 Self-checking bench of the converter start control.
 Assumes the CPU model drives all register cycles.
*/
`include "acsc_defs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acsc_pkg::*;

   localparam int TRK = `ACSC_TRACK_TICKS * `ACSC_SAR_DIV;
   localparam int CNV = `ACSC_CONV_TICKS * `ACSC_SAR_DIV;

   logic           clk;
   logic           rst;
   acsc_sfr_req_t  sfrReq;
   logic [7:0]     sfrRdata;
   logic           sfrRdValid;
   acsc_trig_t     timerOvf;
   logic           externalConvertStartPin;
   logic           windowMatch;
   logic           converterEnable;
   logic           trackActive;
   logic           convActive;
   logic           convDone;
   logic           sarTick;
   logic           sfrHit;
   int             hitCount = 0;
   int             mismatches = 0;
   int             checkCount = 0;
   logic [2:0]     src [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   logic [3:0]     msk [5] = '{4'h8, 4'h2, 4'h4, 4'h0, 4'h1};

   acsc_top DUT (.clk(clk), .rst(rst), .sfrReq(sfrReq),
      .sfrRdata(sfrRdata), .sfrRdValid(sfrRdValid), .sfrHit(sfrHit),
      .timerOvf(timerOvf),
      .externalConvertStartPin(externalConvertStartPin),
      .windowMatch(windowMatch), .converterEnable(converterEnable),
      .trackActive(trackActive), .convActive(convActive), .sarTick(sarTick),
      .convDone(convDone));

   acsc_cpu_model cpu (.clk(clk), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
      .sfrRdValid(sfrRdValid));

   // Every hitting access counts once, while its request stands
   always @(posedge clk) begin
      if (sfrHit === 1'b1) begin
         hitCount++;
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string nm, input logic [7:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic rd(input logic [7:0] a, input logic b, input logic [2:0] i,
                     input logic ev, input logic [7:0] e);
      logic [7:0] q;
      logic       v;
      cpu.acc(a, 1'b0, b, i, 8'h00, q, v);
      check("rdValid", 8'(v), 8'(ev));
      if (ev) begin
         check("rdata", q, e);
      end
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic b, input logic [2:0] i,
                     input logic [7:0] d);
      logic [7:0] q;
      logic       v;
      cpu.acc(a, 1'b1, b, i, d, q, v);
   endtask : wr

   task automatic fire(input logic [3:0] m, input logic p);
      timerOvf = acsc_trig_t'(m);
      externalConvertStartPin = p;
      @(posedge clk);
      #1;
      timerOvf = '0;
   endtask : fire

   // Counts tracking and converting cycles of one started conversion
   task automatic conv(input int expTrack);
      int n;
      int t;
      int c;
      int s;
      n = 0;
      t = 0;
      c = 0;
      s = 0;
      while (!(trackActive || convActive) && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      while (trackActive === 1'b1 && t < 100) begin
         @(posedge clk);
         #1;
         t++;
      end
      while (convActive === 1'b1 && c < 300) begin
         s = s + int'(sarTick);
         @(posedge clk);
         #1;
         c++;
      end
      if (n == 20 || c == 300) begin
         mismatches++;
         finish_test();
      end
      check("trackLen", 8'(t), 8'(expTrack));
      check("convLen", 8'(c), 8'(CNV));
      check("convTicks", 8'(s), 8'(`ACSC_CONV_TICKS));
      check("convDone", 8'(convDone), 8'h01);
   endtask : conv

   initial begin
      #200000;
      mismatches++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      timerOvf = '0;
      externalConvertStartPin = 1'b0;
      windowMatch = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'h00);
      check("trackOff", 8'(trackActive), 8'h00);
      wr(8'hE8, 1'b1, 3'h7, 8'h01);
      check("enable", 8'(converterEnable), 8'h01);
      check("trackIdle", 8'(trackActive), 8'h01);
      rd(8'hE8, 1'b1, 3'h7, 1'b1, 8'h01);
      rd(8'hE9, 1'b1, 3'h7, 1'b0, 8'h00);
      rd(8'hE9, 1'b0, 3'h0, 1'b0, 8'h00);
      rd(8'h68, 1'b0, 3'h0, 1'b0, 8'h00);
      windowMatch = 1'b1;
      wr(8'hE8, 1'b0, 3'h0, 8'h90);
      conv(0);
      windowMatch = 1'b0;
      check("trackBack", 8'(trackActive), 8'h01);
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'hA8);
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'hA8);
      wr(8'hE8, 1'b0, 3'h0, 8'h80);
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'h80);
      // Track mode must already be set when the start write lands
      wr(8'hE8, 1'b1, 3'h6, 8'h01);
      check("bitTm", 8'(trackActive), 8'h00);
      wr(8'hE8, 1'b0, 3'h0, 8'hD0);
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'hD0);
      conv(TRK - 2);
      rd(8'hE8, 1'b0, 3'h0, 1'b1, 8'hE0);
      for (int k = 0; k < 5; k++) begin
         wr(8'hE8, 1'b0, 3'h0, {5'b11000, src[k]});
         fire(~msk[k], src[k] != 3'h4);
         repeat (5) @(posedge clk);
         #1;
         externalConvertStartPin = 1'b0;
         check("noStart", 8'(trackActive | convActive), 8'h00);
         @(posedge clk);
         #1;
         fire(msk[k], src[k] == 3'h4);
         conv(TRK);
         externalConvertStartPin = 1'b0;
         rd(8'hE8, 1'b0, 3'h0, 1'b1, {5'b11100, src[k]});
      end
      check("hits", 8'(hitCount), 8'h16);
      finish_test();
   end
endmodule : tb
`default_nettype wire
